// ---- rtl/csf_arith.sv ----
// Combinational flag evaluator for add, subtract, logical and rotate results
`timescale 1ns/1ps
module csf_arith (
   // Operation
   input wire logic [2:0] op,
   input wire logic [7:0] opa,
   input wire logic [7:0] opb,
   input wire logic [7:0] flags_in,
   // Results
   output logic [7:0] result,
   output logic [7:0] flags_out
);
   logic [4:0] low_sum;
   logic [7:0] low7_sum;
   logic [8:0] full_sum;
   logic [7:0] b_eff;
   logic cin;
   logic c7;
   logic wrap;
   logic zero;

   always_comb begin
      flags_out = flags_in;
      result = 8'h00;
      cin = 1'b0;
      b_eff = opb;
      if (op == csf_pkg::CSF_OP_SUB || op == csf_pkg::CSF_OP_SUBB) begin
         // Subtract as a + ~b + 1 (a + ~b + carry flag for SUBB); carry out high means no borrow
         b_eff = ~opb;
         cin = (op == csf_pkg::CSF_OP_SUB) ? 1'b1 : flags_in[csf_pkg::BIT_CARRY];
      end
      low_sum = {1'b0, opa[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, cin};
      low7_sum = {1'b0, opa[6:0]} + {1'b0, b_eff[6:0]} + {7'h00, cin};
      full_sum = {1'b0, opa} + {1'b0, b_eff} + {8'h00, cin};
      c7 = low7_sum[7];
      wrap = c7 ^ full_sum[8];
      zero = (full_sum[7:0] == 8'h00);
      case (op)
         csf_pkg::CSF_OP_ADD, csf_pkg::CSF_OP_SUB, csf_pkg::CSF_OP_SUBB: begin
            result = full_sum[7:0];
            flags_out[csf_pkg::BIT_CARRY] = full_sum[8];
            flags_out[csf_pkg::BIT_HALF] = low_sum[4];
            flags_out[csf_pkg::BIT_ZERO] = zero;
            flags_out[csf_pkg::BIT_WRAP] = wrap;
            flags_out[csf_pkg::BIT_SXOR] = wrap ^ full_sum[7];
            if (op == csf_pkg::CSF_OP_SUB) begin
               flags_out[csf_pkg::BIT_MBZ] = zero;
            end else if (op == csf_pkg::CSF_OP_SUBB) begin
               flags_out[csf_pkg::BIT_MBZ] = flags_in[csf_pkg::BIT_MBZ] & zero;
            end
         end
         csf_pkg::CSF_OP_LOGIC: begin
            result = opa;
            flags_out[csf_pkg::BIT_ZERO] = (opa == 8'h00);
         end
         csf_pkg::CSF_OP_RLC: begin
            result = {opa[6:0], flags_in[csf_pkg::BIT_CARRY]};
            flags_out[csf_pkg::BIT_CARRY] = opa[7];
         end
         csf_pkg::CSF_OP_RRC: begin
            result = {flags_in[csf_pkg::BIT_CARRY], opa[7:1]};
            flags_out[csf_pkg::BIT_CARRY] = opa[0];
         end
         default: begin
            result = opa;
         end
      endcase
   end
endmodule

// ---- rtl/csf_pkg.sv ----
// Package with flag positions, register offsets and operation codes of the condition flag block
package csf_pkg;
   // ****************************************************************
   // Flag positions
   // ****************************************************************
   localparam int unsigned BIT_CARRY = 0;
   localparam int unsigned BIT_HALF = 1;
   localparam int unsigned BIT_ZERO = 2;
   localparam int unsigned BIT_WRAP = 3;
   localparam int unsigned BIT_SLEEP = 4;
   localparam int unsigned BIT_WDOG = 5;
   localparam int unsigned BIT_MBZ = 6;
   localparam int unsigned BIT_SXOR = 7;
   localparam logic [7:0] SYS_MASK = 8'h30;
   localparam logic [7:0] FLAGS_RESET = 8'h00;

   // ****************************************************************
   // Register map
   // ****************************************************************
   localparam logic [3:0] ADDR_FLAGS = 4'h0;
   localparam logic [3:0] ADDR_IRQ_STAT = 4'h1;
   localparam logic [3:0] ADDR_IRQ_EN = 4'h2;
   localparam logic [3:0] ADDR_IRQ_CLR = 4'h3;
   localparam logic [7:0] READ_UNMAPPED = 8'h00;
   localparam int unsigned IRQ_WDOG = 0;
   localparam int unsigned IRQ_SLEEP = 1;
   localparam int unsigned IRQ_BITS = 2;

   // ****************************************************************
   // Operations and system events
   // ****************************************************************
   typedef enum logic [2:0] {
      CSF_OP_NONE = 3'b000,
      CSF_OP_ADD = 3'b001,
      CSF_OP_SUB = 3'b010,
      CSF_OP_SUBB = 3'b011,
      CSF_OP_LOGIC = 3'b100,
      CSF_OP_RLC = 3'b101,
      CSF_OP_RRC = 3'b110
   } csf_op_e;

   typedef enum logic [1:0] {
      CSF_SYS_NONE = 2'b00,
      CSF_SYS_CLRWDT = 2'b01,
      CSF_SYS_HALT = 2'b10,
      CSF_SYS_TIMEOUT = 2'b11
   } csf_sys_e;
endpackage

// ---- rtl/csf_sysflags.sv ----
// Next-value logic of the watchdog-expired and sleep-entered system flags
`timescale 1ns/1ps
module csf_sysflags (
   // Event
   input wire logic [1:0] sys_event,
   input wire logic wdog_in,
   input wire logic sleep_in,
   // Next values
   output logic wdog_out,
   output logic sleep_out
);
   always_comb begin
      wdog_out = wdog_in;
      sleep_out = sleep_in;
      case (sys_event)
         csf_pkg::CSF_SYS_CLRWDT: begin
            wdog_out = 1'b0;
            sleep_out = 1'b0;
         end
         csf_pkg::CSF_SYS_HALT: begin
            wdog_out = 1'b0;
            sleep_out = 1'b1;
         end
         csf_pkg::CSF_SYS_TIMEOUT: begin
            wdog_out = 1'b1;
         end
         default: begin
            wdog_out = wdog_in;
         end
      endcase
   end
endmodule

// ---- rtl/csf_top.sv ----
// Condition flag register of the core with register port and event interrupt
//
// The plain strobed port and the placing of the registers were decided locally.
`timescale 1ns/1ps
module csf_top (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic srst,
   // Register port
   input wire logic [3:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   // Core operation
   input wire logic op_valid,
   input wire logic [2:0] op_code,
   input wire logic [7:0] op_a,
   input wire logic [7:0] op_b,
   // System events
   input wire logic [1:0] sys_event,
   // Results
   output logic [7:0] op_result,
   output logic [7:0] flags,
   output logic irq
);
   // ****************************************************************
   // State
   // ****************************************************************
   typedef struct packed {
      logic [7:0] flags;
      logic [7:0] rdata;
      logic [7:0] result;
      logic [1:0] irq_stat;
      logic [1:0] irq_en;
      logic irq;
   } csf_state_s;

   csf_state_s st;
   csf_state_s next_st;
   logic [7:0] alu_flags;
   logic [7:0] alu_result;
   logic next_wdog;
   logic next_sleep;

   csf_arith i_csf_arith (
      .op(op_valid ? op_code : csf_pkg::CSF_OP_NONE),
      .opa(op_a),
      .opb(op_b),
      .flags_in(st.flags),
      .result(alu_result),
      .flags_out(alu_flags)
   );

   csf_sysflags i_csf_sysflags (
      .sys_event(sys_event),
      .wdog_in(st.flags[csf_pkg::BIT_WDOG]),
      .sleep_in(st.flags[csf_pkg::BIT_SLEEP]),
      .wdog_out(next_wdog),
      .sleep_out(next_sleep)
   );

   function automatic logic hit(input logic [3:0] a, input logic [3:0] target);
      hit = (a == target);
   endfunction

   // ****************************************************************
   // Next state
   // ****************************************************************
   always_comb begin
      logic [1:0] events;
      events = 2'b00;
      next_st = st;
      // Operation results first; a register write in the same cycle wins
      if (op_valid) begin
         next_st.result = alu_result;
         next_st.flags = alu_flags;
      end
      if (reg_wr && hit(reg_addr, csf_pkg::ADDR_FLAGS)) begin
         next_st.flags = (reg_wdata & ~csf_pkg::SYS_MASK) | (st.flags & csf_pkg::SYS_MASK);
      end
      // System flags only ever take the event logic's value
      next_st.flags[csf_pkg::BIT_WDOG] = next_wdog;
      next_st.flags[csf_pkg::BIT_SLEEP] = next_sleep;
      events[csf_pkg::IRQ_WDOG] = next_wdog & ~st.flags[csf_pkg::BIT_WDOG];
      events[csf_pkg::IRQ_SLEEP] = next_sleep & ~st.flags[csf_pkg::BIT_SLEEP];
      if (reg_wr && hit(reg_addr, csf_pkg::ADDR_IRQ_EN)) begin
         next_st.irq_en = reg_wdata[csf_pkg::IRQ_BITS-1:0];
      end
      // A new event wins over a clear in the same cycle
      if (reg_wr && hit(reg_addr, csf_pkg::ADDR_IRQ_CLR)) begin
         next_st.irq_stat = st.irq_stat & ~reg_wdata[csf_pkg::IRQ_BITS-1:0];
      end
      next_st.irq_stat = next_st.irq_stat | events;
      next_st.irq = |(next_st.irq_stat & next_st.irq_en);
      next_st.rdata = 8'h00;
      if (reg_rd) begin
         case (reg_addr)
            csf_pkg::ADDR_FLAGS: next_st.rdata = st.flags;
            csf_pkg::ADDR_IRQ_STAT: next_st.rdata = {6'h00, st.irq_stat};
            csf_pkg::ADDR_IRQ_EN: next_st.rdata = {6'h00, st.irq_en};
            default: next_st.rdata = csf_pkg::READ_UNMAPPED;
         endcase
      end
   end

   // Flags are never pushed anywhere on calls or interrupts; software saves them
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         st <= '0;
         st.flags <= csf_pkg::FLAGS_RESET;
      end else begin
         st <= next_st;
      end
   end

   assign reg_rdata = st.rdata;
   assign op_result = st.result;
   assign flags = st.flags;
   assign irq = st.irq;

   // ****************************************************************
   // Checks
   // ****************************************************************
   a_sys_write_guard: assert property (@(posedge ref_clk) disable iff (srst)
      (reg_wr && reg_addr == csf_pkg::ADDR_FLAGS && sys_event == csf_pkg::CSF_SYS_NONE)
      |=> flags[5:4] == $past(flags[5:4])) else $error("System flag changed by write");
   a_plain_write: assert property (@(posedge ref_clk) disable iff (srst)
      (reg_wr && reg_addr == csf_pkg::ADDR_FLAGS)
      |=> (flags & 8'hcf) == ($past(reg_wdata) & 8'hcf)) else $error("Flag write lost");
   a_wdog_hold: assert property (@(posedge ref_clk) disable iff (srst)
      sys_event == csf_pkg::CSF_SYS_NONE |=> $stable(flags[5])) else $error("Watchdog flag moved");
   a_wdog_set: assert property (@(posedge ref_clk) disable iff (srst)
      sys_event == csf_pkg::CSF_SYS_TIMEOUT |=> flags[5]) else $error("Time-out not recorded");
   a_halt_flags: assert property (@(posedge ref_clk) disable iff (srst)
      sys_event == csf_pkg::CSF_SYS_HALT |=> flags[4] && !flags[5]) else $error("Halt flags wrong");
   a_clr_flags: assert property (@(posedge ref_clk) disable iff (srst)
      sys_event == csf_pkg::CSF_SYS_CLRWDT |=> flags[5:4] == 2'b00) else $error("Clear flags wrong");
   a_add_carry: assert property (@(posedge ref_clk) disable iff (srst)
      (op_valid && op_code == csf_pkg::CSF_OP_ADD && !reg_wr)
      |=> flags[0] == ({1'b0, $past(op_a)} + {1'b0, $past(op_b)} > 9'h0ff))
      else $error("Add carry wrong");
   a_rot_carry: assert property (@(posedge ref_clk) disable iff (srst)
      (op_valid && op_code == csf_pkg::CSF_OP_RLC && !reg_wr)
      |=> flags[0] == $past(op_a[7]) && op_result[0] == $past(flags[0]))
      else $error("Rotate carry wrong");
   a_rrc_carry: assert property (@(posedge ref_clk) disable iff (srst)
      (op_valid && op_code == csf_pkg::CSF_OP_RRC && !reg_wr)
      |=> flags[0] == $past(op_a[0]) && op_result[7] == $past(flags[0]))
      else $error("Right rotate carry wrong");
   a_zero_flag: assert property (@(posedge ref_clk) disable iff (srst)
      // Rotates leave the zero flag alone, so only arithmetic and logical codes count
      (op_valid && !reg_wr && (op_code == csf_pkg::CSF_OP_ADD || op_code == csf_pkg::CSF_OP_SUB
      || op_code == csf_pkg::CSF_OP_SUBB || op_code == csf_pkg::CSF_OP_LOGIC))
      |=> flags[2] == (op_result == 8'h00)) else $error("Zero flag wrong");
   a_sign_xor: assert property (@(posedge ref_clk) disable iff (srst)
      (op_valid && op_code == csf_pkg::CSF_OP_ADD && !reg_wr)
      |=> flags[7] == (flags[3] ^ op_result[7])) else $error("Sign xor wrong");
   a_sub_mbz: assert property (@(posedge ref_clk) disable iff (srst)
      (op_valid && op_code == csf_pkg::CSF_OP_SUB && !reg_wr)
      |=> flags[6] == flags[2]) else $error("Multi-byte zero wrong");
   a_reset_sys: assert property (@(posedge ref_clk)
      srst |=> flags[5:4] == 2'b00) else $error("System flags not cleared");
endmodule

// ---- verif/csf_top_tb.sv ----
// Self-checking testbench of the condition flag block
`timescale 1ns/1ps
module csf_top_tb;
   // ****************************************************************
   // Signals
   // ****************************************************************
   logic ref_clk;
   logic srst;
   logic [3:0] reg_addr;
   logic [7:0] reg_wdata;
   logic reg_wr;
   logic reg_rd;
   logic [7:0] reg_rdata;
   logic op_valid;
   logic [2:0] op_code;
   logic [7:0] op_a;
   logic [7:0] op_b;
   logic [1:0] sys_event;
   logic [7:0] op_result;
   logic [7:0] flags;
   logic irq;
   logic [7:0] model;
   int fails;
   int check_count;
   int cycles;

   csf_top i_csf_top (.ref_clk(ref_clk), .srst(srst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .op_valid(op_valid), .op_code(op_code), .op_a(op_a), .op_b(op_b),
      .sys_event(sys_event), .op_result(op_result), .flags(flags), .irq(irq));

   initial begin
      ref_clk = 1'b0;
      forever #50 ref_clk = ~ref_clk;
   end

   // Well above the hundred or so cycles the scenarios need
   always @(posedge ref_clk) begin
      cycles <= cycles + 1;
      if (cycles == 2000) begin
         fails = fails + 1;
         test_done();
      end
   end

   // ****************************************************************
   // Shared tasks
   // ****************************************************************
   task automatic test_done;
      $display("fails=%0d check_count=%0d", fails, check_count);
      if (fails == 0 && check_count > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
      check_count = check_count + 1;
      if (got !== exp) begin
         fails = fails + 1;
         $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   // Shadow keeps the system bits, since register writes may not touch them
   task automatic reg_write(input logic [3:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
      #1;
      if (a == csf_pkg::ADDR_FLAGS) begin
         model = (model & csf_pkg::SYS_MASK) | (d & ~csf_pkg::SYS_MASK);
         chk(flags, model, "flags after write");
      end
   endtask

   task automatic reg_read(input logic [3:0] a, input logic [7:0] exp);
      @(posedge ref_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1;
      chk(reg_rdata, exp, "read data");
   endtask

   task automatic sys_pulse(input csf_pkg::csf_sys_e ev);
      @(posedge ref_clk);
      sys_event <= ev;
      @(posedge ref_clk);
      sys_event <= csf_pkg::CSF_SYS_NONE;
      #1;
      case (ev)
         csf_pkg::CSF_SYS_TIMEOUT: model[csf_pkg::BIT_WDOG] = 1'b1;
         csf_pkg::CSF_SYS_HALT: model[5:4] = 2'b01;
         default: model[5:4] = 2'b00;
      endcase
      chk(flags, model, "flags after system event");
   endtask

   // Expected flags are built from carries into bit 4, into bit 7 and out of bit 7
   task automatic run_op(input csf_pkg::csf_op_e op, input logic [7:0] a, input logic [7:0] b);
      logic [7:0] bb;
      logic cin;
      logic [8:0] s;
      logic [4:0] h;
      logic [7:0] m;
      logic [7:0] res;
      bb = (op == csf_pkg::CSF_OP_ADD) ? b : ~b;
      cin = (op == csf_pkg::CSF_OP_ADD) ? 1'b0 : (op == csf_pkg::CSF_OP_SUB) ? 1'b1 : model[0];
      s = {1'b0, a} + {1'b0, bb} + {8'h00, cin};
      h = {1'b0, a[3:0]} + {1'b0, bb[3:0]} + {4'h0, cin};
      m = {1'b0, a[6:0]} + {1'b0, bb[6:0]} + {7'h00, cin};
      res = s[7:0];
      case (op)
         csf_pkg::CSF_OP_LOGIC: begin
            res = a;
            model[2] = (a == 8'h00);
         end
         csf_pkg::CSF_OP_RLC: begin
            res = {a[6:0], model[0]};
            model[0] = a[7];
         end
         csf_pkg::CSF_OP_RRC: begin
            res = {model[0], a[7:1]};
            model[0] = a[0];
         end
         default: begin
            if (op == csf_pkg::CSF_OP_SUB) begin
               model[6] = (s[7:0] == 8'h00);
            end else if (op == csf_pkg::CSF_OP_SUBB) begin
               model[6] = model[6] & (s[7:0] == 8'h00);
            end
            model[3:0] = {m[7] ^ s[8], s[7:0] == 8'h00, h[4], s[8]};
            model[7] = m[7] ^ s[8] ^ s[7];
         end
      endcase
      @(posedge ref_clk);
      op_valid <= 1'b1;
      op_code <= op;
      op_a <= a;
      op_b <= b;
      @(posedge ref_clk);
      op_valid <= 1'b0;
      #1;
      chk(flags, model, "flags after operation");
      chk(op_result, res, "operation result");
   endtask

   // ****************************************************************
   // Scenarios
   // ****************************************************************
   task automatic t_reset;
      chk(flags, 8'h00, "flags after reset");
      reg_read(csf_pkg::ADDR_FLAGS, 8'h00);
   endtask

   task automatic t_write;
      reg_write(csf_pkg::ADDR_FLAGS, 8'hFF);
      reg_read(csf_pkg::ADDR_FLAGS, 8'hCF);
      reg_write(csf_pkg::ADDR_FLAGS, 8'h00);
   endtask

   task automatic t_system;
      sys_pulse(csf_pkg::CSF_SYS_HALT);
      reg_write(csf_pkg::ADDR_FLAGS, 8'hFF);
      sys_pulse(csf_pkg::CSF_SYS_TIMEOUT);
      reg_write(csf_pkg::ADDR_FLAGS, 8'h00);
      run_op(csf_pkg::CSF_OP_SUB, 8'h05, 8'h05);
      sys_pulse(csf_pkg::CSF_SYS_HALT);
      sys_pulse(csf_pkg::CSF_SYS_CLRWDT);
   endtask

   task automatic t_irq;
      reg_write(csf_pkg::ADDR_IRQ_EN, 8'h00);
      reg_write(csf_pkg::ADDR_IRQ_CLR, 8'h03);
      reg_read(csf_pkg::ADDR_IRQ_STAT, 8'h00);
      sys_pulse(csf_pkg::CSF_SYS_TIMEOUT);
      reg_read(csf_pkg::ADDR_IRQ_STAT, 8'h01);
      chk({7'h00, irq}, 8'h00, "masked interrupt");
      reg_write(csf_pkg::ADDR_IRQ_EN, 8'h03);
      @(posedge ref_clk);
      #1;
      chk({7'h00, irq}, 8'h01, "enabled interrupt");
      reg_write(csf_pkg::ADDR_IRQ_STAT, 8'h00);
      reg_read(csf_pkg::ADDR_IRQ_STAT, 8'h01);
      reg_write(csf_pkg::ADDR_IRQ_CLR, 8'h01);
      @(posedge ref_clk);
      #1;
      chk({7'h00, irq}, 8'h00, "cleared interrupt");
      sys_pulse(csf_pkg::CSF_SYS_CLRWDT);
      sys_pulse(csf_pkg::CSF_SYS_HALT);
      reg_read(csf_pkg::ADDR_IRQ_STAT, 8'h02);
      chk({7'h00, irq}, 8'h01, "sleep interrupt");
      reg_read(csf_pkg::ADDR_IRQ_EN, 8'h03);
      reg_read(4'hF, csf_pkg::READ_UNMAPPED);
   endtask

   task automatic t_arith;
      run_op(csf_pkg::CSF_OP_ADD, 8'h7F, 8'h01);
      run_op(csf_pkg::CSF_OP_ADD, 8'hFF, 8'h01);
      run_op(csf_pkg::CSF_OP_ADD, 8'h80, 8'h80);
      run_op(csf_pkg::CSF_OP_SUB, 8'h10, 8'h01);
      run_op(csf_pkg::CSF_OP_SUB, 8'h80, 8'h01);
      run_op(csf_pkg::CSF_OP_SUB, 8'h00, 8'h01);
      run_op(csf_pkg::CSF_OP_SUB, 8'h05, 8'h05);
      run_op(csf_pkg::CSF_OP_SUBB, 8'h03, 8'h03);
      run_op(csf_pkg::CSF_OP_SUBB, 8'h01, 8'h00);
      run_op(csf_pkg::CSF_OP_SUBB, 8'h00, 8'h00);
      reg_write(csf_pkg::ADDR_FLAGS, 8'h40);
      run_op(csf_pkg::CSF_OP_SUBB, 8'h05, 8'h04);
      run_op(csf_pkg::CSF_OP_LOGIC, 8'h00, 8'h00);
      run_op(csf_pkg::CSF_OP_LOGIC, 8'h5A, 8'h00);
      run_op(csf_pkg::CSF_OP_RLC, 8'h81, 8'h00);
      run_op(csf_pkg::CSF_OP_RLC, 8'h40, 8'h00);
      run_op(csf_pkg::CSF_OP_RRC, 8'h01, 8'h00);
      run_op(csf_pkg::CSF_OP_RRC, 8'h02, 8'h00);
   endtask

   // Write, operation and time-out in one cycle: write wins the plain bits, event the system bits
   task automatic t_collide;
      @(posedge ref_clk);
      reg_wr <= 1'b1;
      reg_addr <= csf_pkg::ADDR_FLAGS;
      reg_wdata <= 8'h00;
      sys_event <= csf_pkg::CSF_SYS_TIMEOUT;
      op_valid <= 1'b1;
      op_code <= csf_pkg::CSF_OP_ADD;
      op_a <= 8'hFF;
      op_b <= 8'h01;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
      sys_event <= csf_pkg::CSF_SYS_NONE;
      op_valid <= 1'b0;
      #1;
      model = (model & 8'h10) | 8'h20;
      chk(flags, model, "flags after collision");
      chk(op_result, 8'h00, "result after collision");
   endtask

   // Reset in mid-run with the watchdog flag and an interrupt pending
   task automatic t_midreset;
      @(posedge ref_clk);
      srst <= 1'b1;
      repeat (2) @(posedge ref_clk);
      srst <= 1'b0;
      #1;
      model = 8'h00;
      chk(flags, model, "flags after second reset");
      chk({7'h00, irq}, 8'h00, "interrupt after second reset");
      reg_read(csf_pkg::ADDR_IRQ_STAT, 8'h00);
   endtask

   // ****************************************************************
   // Main sequence
   // ****************************************************************
   initial begin
      srst = 1'b1;
      reg_addr = 4'h0;
      reg_wdata = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      op_valid = 1'b0;
      op_code = 3'h0;
      op_a = 8'h00;
      op_b = 8'h00;
      sys_event = 2'b00;
      model = 8'h00;
      fails = 0;
      check_count = 0;
      cycles = 0;
      repeat (2) @(posedge ref_clk);
      srst <= 1'b0;
      #1;
      t_reset();
      t_write();
      t_system();
      t_irq();
      t_arith();
      t_collide();
      t_midreset();
      test_done();
   end
endmodule
